// ---- tb/amc_ctrl_assertions.sv ----
// concurrent checks on the control block ports
`timescale 1ns/1ps
module amc_ctrl_assertions
   import amc_pkg::*;
(
   input wire logic         clk_sys_i,
   input wire logic         nrst_i,
   input wire amc_pins_t    pins_i,
   input wire amc_axi_req_t axi_req_i,
   input wire amc_axi_rsp_t axi_rsp_o,
   input wire logic         data_oe_n_o,
   input wire logic         ref_en_o,
   input wire logic         bias_en_o,
   input wire logic         dcs_active_o,
   input wire logic         span2_o,
   input wire logic         pscale_o
);
   logic [2:0]  age;
   logic [14:0] p1, p2, p3;
   logic        st;
   amc_lvl_t    sp, pw, fm, oe;
   function automatic amc_lvl_t ev(input amc_pin_t p);
      return p.driven ? p.lvl : LVL_GND;
   endfunction
   assign sp = ev(pins_i.span);
   assign pw = ev(pins_i.pwr);
   assign fm = ev(pins_i.fmt);
   assign oe = ev(pins_i.oen);
   // straps held steady long enough to pass the synchronizer
   assign st = age == 3'h7 && pins_i[15:1] == p1 && p1 == p2 && p2 == p3;
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i)
         age <= 3'h0;
      else if (age != 3'h7)
         age <= age + 3'h1;
      p1 <= pins_i[15:1];
      p2 <= p1;
      p3 <= p2;
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   chk_oe_hiz:
   assert property (st |-> data_oe_n_o == (oe == LVL_SUP || pw != LVL_GND))
      else $error("output enable mismatch");
   chk_ref_power:
   assert property (st |-> ref_en_o == (pw != LVL_SUP)
      && bias_en_o == ref_en_o)
      else $error("reference enable mismatch");
   chk_span_decode:
   assert property (st |-> span2_o == (sp == LVL_GND || sp == LVL_THIRD)
      && pscale_o == (sp == LVL_THIRD || sp == LVL_TWO3))
      else $error("span decode mismatch");
   chk_dcs_decode:
   assert property (st |-> dcs_active_o ==
      ((fm == LVL_THIRD || fm == LVL_TWO3) && pw != LVL_SUP))
      else $error("stabilizer decode mismatch");
   chk_wr_answer:
   assert property (axi_req_i.awvalid && axi_rsp_o.awready && axi_req_i.wvalid
      && axi_rsp_o.wready |=> axi_rsp_o.bvalid)
      else $error("write response late");
   chk_wr_hold:
   assert property (axi_rsp_o.bvalid && !axi_req_i.bready
      |=> axi_rsp_o.bvalid && $stable(axi_rsp_o.bresp))
      else $error("write response dropped");
   chk_rd_answer:
   assert property (axi_req_i.arvalid && axi_rsp_o.arready
      |=> axi_rsp_o.rvalid)
      else $error("read response late");
   chk_rd_hold:
   assert property (axi_rsp_o.rvalid && !axi_req_i.rready |=> axi_rsp_o.rvalid
      && $stable(axi_rsp_o.rdata) && $stable(axi_rsp_o.rresp))
      else $error("read response dropped");
endmodule
bind amc_ctrl amc_ctrl_assertions u_chk (.clk_sys_i(clk_sys_i),
   .nrst_i(nrst_i), .pins_i(pins_i), .axi_req_i(axi_req_i),
   .axi_rsp_o(axi_rsp_o), .data_oe_n_o(data_oe_n_o), .ref_en_o(ref_en_o),
   .bias_en_o(bias_en_o), .dcs_active_o(dcs_active_o), .span2_o(span2_o),
   .pscale_o(pscale_o));

// ---- tb/amc_rx.sv ----
// receiving logic that captures settled words from the parallel bus
`timescale 1ns/1ps
module amc_rx
   import amc_pkg::*;
(
   input  wire logic              clk_sys_i,
   input  wire logic [CODE_W-1:0] data_i,
   input  wire logic              oe_n_i,
   input  wire logic              ok_i,
   output logic      [CODE_W-1:0] word_o
);
   logic [CODE_W-1:0] bus;
   // released bus shows the inverse of the last word
   assign bus = oe_n_i ? ~word_o : data_i;
   always @(posedge clk_sys_i) begin
      if (!oe_n_i && ok_i) begin
         word_o <= bus;
      end
   end
endmodule

// ---- tb/tb_amc_ctrl.sv ----
// self-checking bench for the converter mode and output control
`timescale 1ns/1ps
module tb_amc_ctrl
   import amc_pkg::*;
;
   localparam logic [2:0] F = 3'h0;
   localparam logic [2:0] G = 3'h4;
   localparam logic [2:0] T = 3'h5;
   localparam logic [2:0] W = 3'h6;
   localparam logic [2:0] S = 3'h7;
   localparam logic [CODE_W-1:0] CA = 12'hA5C;
   localparam logic [CODE_W-1:0] CB = 12'h3C1;
   typedef struct packed {
      logic [14:0] p;
      logic [7:0]  e;
   } amc_row_t;
   amc_row_t rows [11] = '{
      '{{F, F, F, F, F}, 8'h08}, '{{S, G, S, G, G}, 8'h01},
      '{{W, G, W, G, G}, 8'h15}, '{{T, G, T, G, G}, 8'h1C},
      '{{G, G, S, S, G}, 8'h0A}, '{{G, G, W, S, G}, 8'h0E},
      '{{G, G, T, S, F}, 8'h0E}, '{{G, T, G, G, G}, 8'hA8},
      '{{G, W, G, G, G}, 8'hA8}, '{{G, G, G, G, S}, 8'h88},
      '{{G, S, W, G, G}, 8'hE9}};
   logic              clk_sys_i = 1'b0;
   logic              nrst_i = 1'b0;
   amc_pins_t         pins;
   logic [14:0]       straps = '0;
   logic              enc = 1'b0;
   logic [CODE_W-1:0] code = '0;
   logic              out_of_range_flag = 1'b0;
   amc_axi_req_t      rq = '0;
   amc_axi_rsp_t      rs;
   logic [CODE_W-1:0] data, rx_word, e;
   logic              otr_o, oe_n, ok, clk_int, ref_en, bias_en;
   logic              duty_cycle_stabilizer, span2, pscale, irq;
   logic [2:0]        ph = 3'h0;
   logic [2:0]        hi = 3'h4;
   logic [31:0]       d;
   logic [1:0]        r;
   int                fail_count = 0;
   int                n_tests = 0;
   int                k;
   amc_ctrl #(.WAKE_CYCLES(8), .DISCH_CYCLES(64)) dut (
      .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(1'b1), .pins_i(pins),
      .core_code_i(code), .core_otr_i(out_of_range_flag), .axi_req_i(rq), .axi_rsp_o(rs),
      .data_o(data), .otr_o(otr_o), .data_oe_n_o(oe_n), .sample_ok_o(ok),
      .clk_int_o(clk_int), .ref_en_o(ref_en), .bias_en_o(bias_en),
      .dcs_active_o(duty_cycle_stabilizer), .span2_o(span2), .pscale_o(pscale), .irq_o(irq));
   amc_rx rx (.clk_sys_i(clk_sys_i), .data_i(data), .oe_n_i(oe_n),
      .ok_i(ok), .word_o(rx_word));
   always #25 clk_sys_i = ~clk_sys_i;
   assign pins = {straps, enc};
   // encode clock of 8 cycles at a fixed rate, duty set by hi
   always @(posedge clk_sys_i) begin
      ph <= ph + 3'h1;
      enc <= (ph + 3'h1) < hi;
   end
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge clk_sys_i);
      rq.awvalid <= 1'b1;
      rq.awaddr <= a;
      rq.wvalid <= 1'b1;
      rq.wdata <= v;
      rq.wstrb <= 4'hF;
      while (aw || w) begin
         @(posedge clk_sys_i);
         if (aw && rs.awready)
            aw = 1'b0;
         if (w && rs.wready)
            w = 1'b0;
         rq.awvalid <= aw;
         rq.wvalid <= w;
      end
      @(posedge clk_sys_i);
      rq.bready <= 1'b1;
      do @(posedge clk_sys_i); while (rs.bvalid !== 1'b1);
      r = rs.bresp;
      rq.bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys_i);
      rq.arvalid <= 1'b1;
      rq.araddr <= a;
      do @(posedge clk_sys_i); while (rs.arready !== 1'b1);
      rq.arvalid <= 1'b0;
      @(posedge clk_sys_i);
      rq.rready <= 1'b1;
      do @(posedge clk_sys_i); while (rs.rvalid !== 1'b1);
      d = rs.rdata;
      r = rs.rresp;
      rq.rready <= 1'b0;
   endtask
   task automatic setp(input logic [14:0] p);
      @(posedge clk_sys_i);
      straps <= p;
      repeat (6) @(posedge clk_sys_i);
   endtask
   task automatic enc_wait(input int n);
      repeat (n)
         do @(posedge clk_sys_i); while (ph !== 3'h7);
   endtask
   task automatic duty(input int exp);
      int h;
      h = 0;
      repeat (16) begin
         @(posedge clk_sys_i);
         h += (clk_int === 1'b1);
      end
      chk(h, exp);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      fail_count++;
      summarize();
   end
   initial begin
      repeat (4) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      rd(REG_SETTINGS);
      chk(d[7:0], 8'h08);
      wr(REG_CONTROL, 32'hFC);
      rd(REG_CONTROL);
      chk({r, d}, {RESP_OKAY, 32'h0});
      wr(REG_SETTINGS, 32'hFF);
      rd(REG_SETTINGS);
      chk({r, d[7:0]}, {RESP_OKAY, 8'h08});
      wr(8'h40, 32'h1);
      chk(r, RESP_SLVERR);
      rd(8'h40);
      chk({r, d}, {RESP_SLVERR, 32'h0});
      $display("test registers done");
      for (k = 0; k < 11; k++) begin
         setp(rows[k].p);
         rd(REG_SETTINGS);
         chk(d[6:3], rows[k].e[6:3]);
         chk(d[1:0], rows[k].e[1:0]);
         chk({oe_n, ref_en, bias_en, pscale, span2, duty_cycle_stabilizer}, {rows[k].e[7],
            {2{rows[k].e[6:5] != 2'h3}}, rows[k].e[4:2]});
      end
      $display("test strap table done");
      code <= CA;
      for (k = 0; k < 3; k++) begin
         setp({G, G, (k == 1) ? S : G, (k == 2) ? S : G, G});
         enc_wait(10);
         e = (k == 0) ? CA : (k == 1) ? CA ^ 12'h800 : CA ^ (CA >> 1);
         chk(data, e);
         chk(rx_word, e);
      end
      $display("test formats done");
      enc_wait(1);
      code <= CB;
      out_of_range_flag <= 1'b1;
      for (k = 1; k <= 8; k++) begin
         enc_wait(1);
         repeat (6) @(posedge clk_sys_i);
         chk({otr_o, data}, (k < 8) ? {1'b0, CA ^ (CA >> 1)}
            : {1'b1, CB ^ (CB >> 1)});
      end
      $display("test latency done");
      rd(REG_IRQ_STATUS);
      chk({irq, d[3]}, 2'b01);
      wr(REG_IRQ_ENABLE, 32'h8);
      chk(irq, 1'b1);
      wr(REG_IRQ_ENABLE, 32'h0);
      chk(irq, 1'b0);
      out_of_range_flag <= 1'b0;
      enc_wait(10);
      wr(REG_IRQ_CLEAR, 32'h8);
      wr(REG_IRQ_ENABLE, 32'h8);
      rd(REG_IRQ_STATUS);
      chk({irq, d[3]}, 2'b00);
      $display("test interrupt done");
      hi <= 3'h1;
      setp({G, G, T, G, G});
      enc_wait(40);
      rd(REG_SETTINGS);
      chk({d[8:7], ok}, 3'b000);
      enc_wait(110);
      rd(REG_SETTINGS);
      chk({d[8:7], ok}, 3'b111);
      duty(8);
      setp({G, G, G, G, G});
      duty(2);
      $display("test stabilizer done");
      setp({G, S, G, G, G});
      repeat (300) @(posedge clk_sys_i);
      straps <= {G, G, G, G, G};
      repeat (4) @(posedge clk_sys_i);
      chk(ok, 1'b0);
      repeat (20) @(posedge clk_sys_i);
      chk(ok, 1'b1);
      $display("test wake done");
      nrst_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      @(posedge clk_sys_i);
      chk({irq, otr_o, data}, '0);
      rd(REG_IRQ_ENABLE);
      chk({r, d}, {RESP_OKAY, 32'h0});
      $display("test reset done");
      summarize();
   end
endmodule

// ---- verilog/amc_ctrl.sv ----
// converter mode decode, power state, clock stabilizer and output stage
`timescale 1ns/1ps
module amc_ctrl
   import amc_pkg::*;
#(
   parameter int unsigned WAKE_CYCLES  = WAKE_CYC,
   parameter int unsigned DISCH_CYCLES = DISCH_CYC
) (
   input  wire logic                clk_sys_i,
   input  wire logic                nrst_i,
   input  wire logic                ce_i,
   input  wire amc_pins_t           pins_i,
   input  wire logic [CODE_W-1:0]   core_code_i,
   input  wire logic                core_otr_i,
   input  wire amc_axi_req_t        axi_req_i,
   output amc_axi_rsp_t             axi_rsp_o,
   output logic [CODE_W-1:0]        data_o,
   output logic                     otr_o,
   output logic                     data_oe_n_o,
   output logic                     sample_ok_o,
   output logic                     clk_int_o,
   output logic                     ref_en_o,
   output logic                     bias_en_o,
   output logic                     dcs_active_o,
   output logic                     span2_o,
   output logic                     pscale_o,
   output logic                     irq_o
);

   localparam int unsigned DIV_RAW = DISCH_CYCLES / WAKE_CYCLES;
   localparam logic [DIV_W-1:0] DISCH_DIV =
      DIV_W'((DIV_RAW < 1) ? 1 : DIV_RAW);
   localparam logic [WAKE_W-1:0] WAKE_MAX = WAKE_W'(WAKE_CYCLES);
   localparam logic [6:0] LOCK_MAX = 7'(DLL_LOCK_CYC);

   // ==========================================================
   // state
   typedef struct packed {
      amc_pins_t                           s1;
      amc_pins_t                           s2;
      logic                                enc_d;
      logic [PER_W-1:0]                    per_cnt;
      logic [PER_W-1:0]                    period;
      logic [6:0]                          lock_cnt;
      logic [PER_W-1:0]                    hi_cnt;
      logic                                clk_int;
      logic [PIPE_STAGES-1:0][CODE_W:0]    pipe;
      logic [CODE_W-1:0]                   dout;
      logic                                out_of_range_flag;
      amc_wake_t                           wst;
      logic [WAKE_W-1:0]                   deficit;
      logic [DIV_W-1:0]                    div_cnt;
      logic [1:0]                          sw_pwr;
      logic [IRQ_N-1:0]                    irq_st;
      logic [IRQ_N-1:0]                    irq_en;
      logic                                aw_hold;
      logic [7:0]                          awaddr;
      logic                                w_hold;
      logic [31:0]                         wdata;
      logic [3:0]                          wstrb;
      logic                                bvalid;
      logic [1:0]                          bresp;
      logic                                rvalid;
      logic [31:0]                         rdata;
      logic [1:0]                          rresp;
   } amc_st_t;

   amc_st_t st_reg;
   amc_st_t st_next;

   // ==========================================================
   // functions
   function automatic amc_lvl_t pin_level(input amc_pin_t p);
      pin_level = p.driven ? p.lvl : LVL_GND;
   endfunction
   function automatic amc_cfg_t decode(input amc_pins_t p,
                                       input logic [1:0] sw);
      amc_lvl_t fl;
      amc_pwr_t pp;
      decode = '0;
      fl = pin_level(p.fmt);
      case (pin_level(p.span))
         LVL_SUP:   begin decode.span2 = 1'b0; decode.pscale = 1'b0; end
         LVL_TWO3:  begin decode.span2 = 1'b0; decode.pscale = 1'b1; end
         LVL_THIRD: begin decode.span2 = 1'b1; decode.pscale = 1'b1; end
         default:   begin decode.span2 = 1'b1; decode.pscale = 1'b0; end
      endcase
      case (pin_level(p.pwr))
         LVL_SUP:   pp = PWR_DOWN;
         LVL_GND:   pp = PWR_NORMAL;
         default:   pp = PWR_STANDBY;
      endcase
      decode.pwr = (pp == PWR_DOWN || sw == PWR_DOWN) ? PWR_DOWN
                 : (pp == PWR_STANDBY || sw == PWR_STANDBY) ? PWR_STANDBY
                 : PWR_NORMAL;
      decode.dcs_en = (fl == LVL_TWO3) || (fl == LVL_THIRD);
      if (pin_level(p.gray) == LVL_SUP) begin
         decode.fmt = FMT_GRAY;
      end else if (fl == LVL_SUP || fl == LVL_TWO3) begin
         decode.fmt = FMT_TWOS;
      end else begin
         decode.fmt = FMT_OFFSET;
      end
   endfunction
   function automatic logic [CODE_W-1:0] fmt_word(
      input logic [CODE_W-1:0] c, input amc_fmt_t f);
      case (f)
         FMT_TWOS: fmt_word = {~c[CODE_W-1], c[CODE_W-2:0]};
         FMT_GRAY: fmt_word = c ^ (c >> 1);
         default:  fmt_word = c;
      endcase
   endfunction

   // ==========================================================
   // next state
   amc_cfg_t         cfg;
   logic             enc_rise;
   logic             locked;
   logic             awr;
   logic             wr;
   logic             a_v;
   logic             w_v;
   logic [7:0]       a_addr;
   logic [IRQ_N-1:0] irq_set;
   logic [IRQ_N-1:0] irq_clr;
   logic [PER_W-1:0] new_per;
   logic             sample_ok;

   always_comb begin
      st_next  = st_reg;
      irq_set  = '0;
      irq_clr  = '0;
      new_per  = '0;
      cfg      = decode(st_reg.s2, st_reg.sw_pwr);
      enc_rise = st_reg.s2.enc & ~st_reg.enc_d;
      locked   = (st_reg.lock_cnt == LOCK_MAX);
      sample_ok = (st_reg.wst == WS_RUN) && (cfg.pwr == PWR_NORMAL)
                  && (!cfg.dcs_en || locked);
      // pin synchronisers
      st_next.s1    = pins_i;
      st_next.s2    = st_reg.s1;
      st_next.enc_d = st_reg.s2.enc;
      // sample rate tracking and stabilizer lock
      if (st_reg.per_cnt != '1) begin
         st_next.per_cnt = st_reg.per_cnt + 1'b1;
      end
      if (enc_rise) begin
         new_per = st_reg.per_cnt + 1'b1;
         st_next.per_cnt = '0;
         st_next.period  = new_per;
         if (new_per != st_reg.period) begin
            st_next.lock_cnt = '0;
            irq_set[IRQ_RATE_CHG] = 1'b1;
            irq_set[IRQ_SCALE_BAD] = cfg.pscale;
         end else if (!locked) begin
            st_next.lock_cnt = st_reg.lock_cnt + 1'b1;
            irq_set[IRQ_LOCKED] = (st_reg.lock_cnt == LOCK_MAX - 1'b1);
         end
      end
      if (cfg.pwr == PWR_DOWN || !cfg.dcs_en) begin
         st_next.lock_cnt = '0;
      end
      // internal clock, falling edge placed at half the period
      if (cfg.pwr == PWR_DOWN) begin
         st_next.clk_int = 1'b0;
         st_next.hi_cnt  = '0;
      end else if (!cfg.dcs_en) begin
         st_next.clk_int = st_reg.s2.enc;
      end else if (enc_rise) begin
         st_next.clk_int = 1'b1;
         st_next.hi_cnt  = (st_reg.period >> 1) - 1'b1;
      end else if (st_reg.hi_cnt != '0) begin
         st_next.hi_cnt  = st_reg.hi_cnt - 1'b1;
      end else begin
         st_next.clk_int = 1'b0;
      end
      // sample pipeline, one step per sample clock
      if (enc_rise && cfg.pwr != PWR_DOWN) begin
         st_next.pipe = {st_reg.pipe[PIPE_STAGES-2:0],
                         {core_otr_i, fmt_word(core_code_i, cfg.fmt)}};
         st_next.dout = st_reg.pipe[PIPE_STAGES-1][CODE_W-1:0];
         st_next.out_of_range_flag  = st_reg.pipe[PIPE_STAGES-1][CODE_W];
         irq_set[IRQ_OVERRANGE] = st_reg.pipe[PIPE_STAGES-1][CODE_W];
      end
      // power state and wake-up delay
      case (st_reg.wst)
         WS_RUN: begin
            if (cfg.pwr != PWR_NORMAL) begin
               st_next.wst = WS_SLEEP;
               st_next.div_cnt = '0;
            end
         end
         WS_SLEEP: begin
            if (cfg.pwr == PWR_DOWN) begin
               if (st_reg.div_cnt >= DISCH_DIV - 1'b1) begin
                  st_next.div_cnt = '0;
                  if (st_reg.deficit < WAKE_MAX) begin
                     st_next.deficit = st_reg.deficit + 1'b1;
                  end
               end else begin
                  st_next.div_cnt = st_reg.div_cnt + 1'b1;
               end
            end
            if (cfg.pwr == PWR_NORMAL) begin
               st_next.wst = WS_WAKE;
            end
         end
         WS_WAKE: begin
            if (cfg.pwr != PWR_NORMAL) begin
               st_next.wst = WS_SLEEP;
            end else if (st_reg.deficit == '0) begin
               st_next.wst = WS_RUN;
               irq_set[IRQ_WAKE_DONE] = 1'b1;
            end else begin
               st_next.deficit = st_reg.deficit - 1'b1;
            end
         end
         default: st_next.wst = WS_RUN;
      endcase
      // register bus, write side
      awr    = ~st_reg.aw_hold & ~st_reg.bvalid;
      wr     = ~st_reg.w_hold & ~st_reg.bvalid;
      a_v    = st_reg.aw_hold | (axi_req_i.awvalid & awr);
      w_v    = st_reg.w_hold | (axi_req_i.wvalid & wr);
      a_addr = st_reg.aw_hold ? st_reg.awaddr : axi_req_i.awaddr;
      if (axi_req_i.awvalid && awr) begin
         st_next.awaddr = axi_req_i.awaddr;
      end
      if (axi_req_i.wvalid && wr) begin
         st_next.wdata = axi_req_i.wdata;
         st_next.wstrb = axi_req_i.wstrb;
      end
      if (st_reg.bvalid && axi_req_i.bready) begin
         st_next.bvalid = 1'b0;
      end
      if (a_v && w_v) begin
         st_next.aw_hold = 1'b0;
         st_next.w_hold  = 1'b0;
         st_next.bvalid  = 1'b1;
         st_next.bresp   = RESP_OKAY;
         case (a_addr)
            REG_CONTROL: if (st_next.wstrb[0]) begin
               st_next.sw_pwr = st_next.wdata[1:0];
            end
            REG_IRQ_CLEAR: if (st_next.wstrb[0]) begin
               irq_clr = st_next.wdata[IRQ_N-1:0];
            end
            REG_IRQ_ENABLE: if (st_next.wstrb[0]) begin
               st_next.irq_en = st_next.wdata[IRQ_N-1:0];
            end
            REG_SETTINGS, REG_IRQ_STATUS, REG_PERIOD: ;
            default: st_next.bresp = RESP_SLVERR;
         endcase
      end else begin
         st_next.aw_hold = a_v;
         st_next.w_hold  = w_v;
      end
      // register bus, read side
      if (st_reg.rvalid && axi_req_i.rready) begin
         st_next.rvalid = 1'b0;
      end
      if (axi_req_i.arvalid && !st_reg.rvalid) begin
         st_next.rvalid = 1'b1;
         st_next.rdata  = '0;
         st_next.rresp  = RESP_OKAY;
         case (axi_req_i.araddr)
            REG_SETTINGS: begin
               st_next.rdata[SET_FMT_LSB +: 2] = cfg.fmt;
               st_next.rdata[SET_DCS]          = cfg.dcs_en;
               st_next.rdata[SET_SPAN2]        = cfg.span2;
               st_next.rdata[SET_PSCALE]       = cfg.pscale;
               st_next.rdata[SET_PWR_LSB +: 2] = cfg.pwr;
               st_next.rdata[SET_LOCKED]       = locked;
               st_next.rdata[SET_READY]        = sample_ok;
            end
            REG_CONTROL:    st_next.rdata[1:0] = st_reg.sw_pwr;
            REG_IRQ_STATUS: st_next.rdata[IRQ_N-1:0] = st_reg.irq_st;
            REG_IRQ_ENABLE: st_next.rdata[IRQ_N-1:0] = st_reg.irq_en;
            REG_PERIOD:     st_next.rdata[PER_W-1:0] = st_reg.period;
            REG_IRQ_CLEAR:  ;
            default:        st_next.rresp = RESP_SLVERR;
         endcase
      end
      // sticky events, a set in the clearing cycle wins
      st_next.irq_st = (st_reg.irq_st & ~irq_clr) | irq_set;
   end
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         st_reg <= '0;
      end else if (ce_i) begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // outputs
   assign axi_rsp_o.awready = ~st_reg.aw_hold & ~st_reg.bvalid;
   assign axi_rsp_o.wready  = ~st_reg.w_hold & ~st_reg.bvalid;
   assign axi_rsp_o.bvalid  = st_reg.bvalid;
   assign axi_rsp_o.bresp   = st_reg.bresp;
   assign axi_rsp_o.arready = ~st_reg.rvalid;
   assign axi_rsp_o.rvalid  = st_reg.rvalid;
   assign axi_rsp_o.rdata   = st_reg.rdata;
   assign axi_rsp_o.rresp   = st_reg.rresp;
   assign data_o       = st_reg.dout;
   assign otr_o        = st_reg.out_of_range_flag;
   assign data_oe_n_o  = pin_level(st_reg.s2.oen) == LVL_SUP
                         || cfg.pwr != PWR_NORMAL;
   assign sample_ok_o  = sample_ok;
   assign clk_int_o    = st_reg.clk_int;
   assign ref_en_o     = cfg.pwr != PWR_DOWN;
   assign bias_en_o    = cfg.pwr != PWR_DOWN;
   assign dcs_active_o = cfg.dcs_en && cfg.pwr != PWR_DOWN;
   assign span2_o      = cfg.span2;
   assign pscale_o     = cfg.pscale;
   assign irq_o        = |(st_reg.irq_st & st_reg.irq_en);

endmodule

// ---- verilog/amc_pkg.sv ----
// shared constants and types for the converter mode and output control
package amc_pkg;
   // ==========================================================
   // clock and timing
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned T_WAKE_NS     = 3000000;
   localparam int unsigned T_DISCH_NS    = 1000000000;
   localparam int unsigned WAKE_CYC      = T_WAKE_NS / CLK_PERIOD_NS;
   localparam int unsigned DISCH_CYC     = T_DISCH_NS / CLK_PERIOD_NS;
   localparam int unsigned DLL_LOCK_CYC  = 100;
   localparam int unsigned PIPE_STAGES   = 8;
   localparam int unsigned CODE_W        = 12;
   localparam int unsigned WAKE_W        = 17;
   localparam int unsigned DIV_W         = 16;
   localparam int unsigned PER_W         = 16;

   // ==========================================================
   // register map, byte addresses
   localparam logic [7:0] REG_SETTINGS   = 8'h00;
   localparam logic [7:0] REG_CONTROL    = 8'h04;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
   localparam logic [7:0] REG_IRQ_CLEAR  = 8'h0C;
   localparam logic [7:0] REG_IRQ_ENABLE = 8'h10;
   localparam logic [7:0] REG_PERIOD     = 8'h14;
   localparam logic [1:0] RESP_OKAY      = 2'h0;
   localparam logic [1:0] RESP_SLVERR    = 2'h2;

   // settings field positions
   localparam int unsigned SET_FMT_LSB   = 0;
   localparam int unsigned SET_DCS       = 2;
   localparam int unsigned SET_SPAN2     = 3;
   localparam int unsigned SET_PSCALE    = 4;
   localparam int unsigned SET_PWR_LSB   = 5;
   localparam int unsigned SET_LOCKED    = 7;
   localparam int unsigned SET_READY     = 8;

   // interrupt bit positions
   localparam int unsigned IRQ_N         = 5;
   localparam int unsigned IRQ_LOCKED    = 0;
   localparam int unsigned IRQ_RATE_CHG  = 1;
   localparam int unsigned IRQ_WAKE_DONE = 2;
   localparam int unsigned IRQ_OVERRANGE = 3;
   localparam int unsigned IRQ_SCALE_BAD = 4;

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      LVL_GND = 2'h0, LVL_THIRD = 2'h1, LVL_TWO3 = 2'h2, LVL_SUP = 2'h3
   } amc_lvl_t;
   typedef enum logic [1:0] {
      PWR_NORMAL = 2'h0, PWR_STANDBY = 2'h1, PWR_DOWN = 2'h3
   } amc_pwr_t;
   typedef enum logic [1:0] {
      FMT_OFFSET = 2'h0, FMT_TWOS = 2'h1, FMT_GRAY = 2'h2
   } amc_fmt_t;
   typedef enum logic [1:0] {
      WS_RUN = 2'h0, WS_SLEEP = 2'h1, WS_WAKE = 2'h3
   } amc_wake_t;

   typedef struct packed {
      logic     driven;
      amc_lvl_t lvl;
   } amc_pin_t;

   typedef struct packed {
      amc_pin_t span;
      amc_pin_t pwr;
      amc_pin_t fmt;
      amc_pin_t gray;
      amc_pin_t oen;
      logic     enc;
   } amc_pins_t;

   typedef struct packed {
      amc_fmt_t fmt;
      logic     dcs_en;
      logic     span2;
      logic     pscale;
      amc_pwr_t pwr;
   } amc_cfg_t;

   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } amc_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } amc_axi_rsp_t;
endpackage
